// [dv/prescaled_reload_down_timer_tb.sv]
// Testbench: register, period, stop and reload checks of the prescaled reload down timer
`timescale 1ns/1ps
module prescaled_reload_down_timer_tb;
  logic        clk    = 1'b0;
  logic        arst_n = 1'b0;
  logic [11:0] addr   = 12'h000;
  logic        rd_en  = 1'b0;
  logic        wr_en  = 1'b0;
  logic [31:0] wdata  = 32'h0;
  logic [3:0]  be     = 4'h0;
  logic        osc    = 1'b0;
  logic        ce     = 1'b1;
  logic [31:0] rdata;
  logic        wreq;
  logic        irq;
  logic [1:0]  route;
  logic [7:0]  q;
  logic [2:0]  src[4] = '{timer_pkg::SRC_UNDIV, timer_pkg::SRC_DIV8, timer_pkg::SRC_OSC,
                          timer_pkg::SRC_DIV2};
  int          fac[4] = '{1, 8, 6, 2};
  int          errors = 0;
  int          checks = 0;
  int          seed   = 44;
  int          cyc    = 0;
  int          irq_q[$];
  int          model[int];
  int          n;
  int          m;
  logic [7:0]  p0;

  // 250 MHz clock
  always #2 clk = ~clk;

  // Cycle count and times of underflow pulses
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_q.push_back(cyc);
  end

  // Oscillator stand-in, six clocks a period, so its edges need the synchroniser
  always @(posedge clk) begin
    if (cyc % 3 == 2) osc <= ~osc;
  end

  prescaled_reload_down_timer i_dut (
    .CLOCK_I           (clk),
    .ARST_N_I          (arst_n),
    .CE_I              (ce),
    .AVS_ADDRESS_I     (addr),
    .AVS_READ_I        (rd_en),
    .AVS_WRITE_I       (wr_en),
    .AVS_WRITEDATA_I   (wdata),
    .AVS_BYTEENABLE_I  (be),
    .AVS_READDATA_O    (rdata),
    .AVS_WAITREQUEST_O (wreq),
    .ONCHIP_OSC_I      (osc),
    .TIMER_IRQ_O       (irq),
    .PIN_ROUTE_O       (route)
  );

  // One bus cycle; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d,
                     input logic [3:0] b);
    int k;
    k = 0;
    @(posedge clk);
    rd_en <= ~wr;
    wr_en <= wr;
    addr  <= {idx, 2'b00};
    wdata <= {24'h0, d};
    be    <= b;
    // Waitrequest and read data are both taken at the answering edge
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    q = rdata[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (k == 50) begin
      errors++;
      $display("wrong value at %0t: bus never answered", $time);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask

  task automatic rd(input logic [9:0] idx);
    bus(1'b0, idx, 8'h00, 4'h0);
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    checks++;
    if (got != exp) begin
      errors++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  // Write and keep the model's read-back image in step; pin and mode mask dead bits
  task automatic wr_m(input logic [9:0] idx, input logic [7:0] d);
    wr(idx, d);
    if (idx == timer_pkg::IDX_PIN_ASSIGN) model[int'(idx)] = int'(d & timer_pkg::PIN_READ_MASK);
    else if (idx == timer_pkg::IDX_MODE) model[int'(idx)] = int'(d & 8'hf7);
    else model[int'(idx)] = int'(d);
  endtask

  task automatic rd_chk(input logic [9:0] idx);
    rd(idx);
    chk_val(q, 8'(model[int'(idx)]));
  endtask

  // Interval between the second and third underflow after the call
  task automatic measure(input int exp);
    int k;
    irq_q.delete();
    k = 0;
    while (irq_q.size() < 3 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    if (irq_q.size() < 3) chk_cnt(irq_q.size(), 3);
    else chk_cnt(irq_q[2] - irq_q[1], exp);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog, several times the expected run
  initial begin
    #80000;
    errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    results();
  end

  // Main sequence
  initial begin
    model[int'(timer_pkg::IDX_CONTROL)]    = 0;
    model[int'(timer_pkg::IDX_IO_CONTROL)] = 0;
    model[int'(timer_pkg::IDX_MODE)]       = 0;
    model[int'(timer_pkg::IDX_PRESCALE)]   = 255;
    model[int'(timer_pkg::IDX_TIMER)]      = 255;
    model[int'(timer_pkg::IDX_PIN_ASSIGN)] = 0;
    model[int'(10'h1ff)]                   = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values and an unmapped place
    foreach (model[i]) rd_chk(10'(i));
    // Pin field codes, set before anything else
    for (int c = 0; c < 4; c++) begin
      wr_m(timer_pkg::IDX_PIN_ASSIGN, {4'hf, 2'b00, 2'(c)});
      rd_chk(timer_pkg::IDX_PIN_ASSIGN);
      chk_val({6'h0, route}, (c == 3) ? 8'h00 : 8'(c));
    end
    bus(1'b1, timer_pkg::IDX_PIN_ASSIGN, 8'h01, 4'h0);
    rd_chk(timer_pkg::IDX_PIN_ASSIGN);
    wr_m(timer_pkg::IDX_PIN_ASSIGN, 8'h01);
    // Only output control and enable bits are free in timer mode
    wr_m(timer_pkg::IDX_IO_CONTROL, 8'($random(seed)) & 8'h06);
    rd_chk(timer_pkg::IDX_IO_CONTROL);
    wr_m(timer_pkg::IDX_IO_CONTROL, 8'h00);
    // Every count source; mode only rewritten while stopped
    for (int s = 0; s < 4; s++) begin
      n = $random(seed) & 3;
      m = $random(seed) & 3;
      wr_m(timer_pkg::IDX_MODE, {1'b0, src[s], 1'b0, timer_pkg::MODE_TIMER});
      rd_chk(timer_pkg::IDX_MODE);
      wr_m(timer_pkg::IDX_PRESCALE, 8'(n));
      rd_chk(timer_pkg::IDX_PRESCALE);
      wr_m(timer_pkg::IDX_TIMER, 8'(m));
      rd_chk(timer_pkg::IDX_TIMER);
      wr(timer_pkg::IDX_CONTROL, 8'h01);
      // Start and status up, stop bit and unused bits read zero; flag may be set
      rd(timer_pkg::IDX_CONTROL);
      chk_val(q & 8'hdf, 8'h03);
      measure(fac[s] * (n + 1) * (m + 1));
      rd(timer_pkg::IDX_PRESCALE);
      chk_val({7'h0, q <= 8'(n)}, 8'h01);
      wr(timer_pkg::IDX_CONTROL, 8'h20);
      rd(timer_pkg::IDX_CONTROL);
      chk_val(q, 8'h20);
      rd(timer_pkg::IDX_PRESCALE);
      p0 = q;
      repeat (20) @(posedge clk);
      rd(timer_pkg::IDX_PRESCALE);
      chk_val(q, p0);
      wr(timer_pkg::IDX_CONTROL, 8'h04);
      rd(timer_pkg::IDX_CONTROL);
      chk_val(q, 8'h00);
      rd(timer_pkg::IDX_PRESCALE);
      chk_val(q, timer_pkg::RST_COUNT);
      rd(timer_pkg::IDX_TIMER);
      chk_val(q, timer_pkg::RST_COUNT);
    end
    // Writes while counting reach the counters only at the next transfer point
    wr(timer_pkg::IDX_MODE, 8'h00);
    wr(timer_pkg::IDX_PRESCALE, 8'h03);
    wr(timer_pkg::IDX_TIMER, 8'h02);
    wr(timer_pkg::IDX_CONTROL, 8'h01);
    measure(12);
    wr(timer_pkg::IDX_TIMER, 8'h05);
    measure(24);
    wr(timer_pkg::IDX_PRESCALE, 8'h01);
    measure(12);
    // Clock enable low for 30 clocks stretches one period by exactly that much
    irq_q.delete();
    while (irq_q.size() < 1) @(posedge clk);
    ce <= 1'b0;
    repeat (30) @(posedge clk);
    ce <= 1'b1;
    while (irq_q.size() < 2) @(posedge clk);
    chk_cnt(irq_q[1] - irq_q[0], 42);
    wr(timer_pkg::IDX_CONTROL, 8'h04);
    // Forbidden mode code must not count even with the fastest setting
    wr(timer_pkg::IDX_MODE, 8'h05);
    wr(timer_pkg::IDX_PRESCALE, 8'h00);
    wr(timer_pkg::IDX_TIMER, 8'h00);
    wr(timer_pkg::IDX_CONTROL, 8'h01);
    irq_q.delete();
    repeat (60) @(posedge clk);
    chk_cnt(irq_q.size(), 0);
    wr(timer_pkg::IDX_CONTROL, 8'h04);
    results();
  end
endmodule

// [rtl/prescaled_reload_down_timer.sv]
// Module: eight-bit prescaler and eight-bit reload down timer, timer mode, Avalon-MM slave
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps

// Notes on behaviour
// - Pin field picks no pin, port1 bit7 or port1 bit5; fourth code unused.
// - Pin register bits 7..4 read zero; bits 3..2 reserved, written zero.
// - Count source is undivided, divide-by-2, divide-by-8 or oscillator clock.
// - Counters count down and reload on underflow without software help.
// - Underflow rate is source over (prescaler plus one) times (timer plus one).
// - Writing one to the start bit begins counting.
// - Clearing the start bit halts counting and keeps counter values.
// - Writing one to the forced stop bit stops counting at once.
// - Each timer underflow raises the interrupt request.
// - Reading prescaler and timer returns live counters, not reload values.
// - A write while stopped loads reload register and counter together.
// - Each stage has reload and counter; timer steps once per prescaler underflow.
// - A prescaler write while counting reaches the counter on the next source edge.
// - A timer write while counting reaches the counter on the next prescaler underflow.
// - Forced stop resets start, status, prescaler and timer; stop bit reads zero.
// - Mode code 000 is timer mode; codes 101 to 111 are forbidden.
// - Source codes 000 undivided, 001 div8, 010 oscillator, 011 div2; others forbidden.
module prescaled_reload_down_timer (
  input  wire logic                          CLOCK_I,           // 250 MHz clock
  input  wire logic                          ARST_N_I,          // Async reset, active low
  input  wire logic                          CE_I,              // Clock enable, freezes all
  input  wire logic [timer_pkg::ADDR_W-1:0]  AVS_ADDRESS_I,     // Byte address
  input  wire logic                          AVS_READ_I,        // Read request
  input  wire logic                          AVS_WRITE_I,       // Write request
  input  wire logic [31:0]                   AVS_WRITEDATA_I,   // Write data
  input  wire logic [3:0]                    AVS_BYTEENABLE_I,  // Byte enables
  output logic      [31:0]                   AVS_READDATA_O,    // Read data
  output logic                               AVS_WAITREQUEST_O, // Stall request
  input  wire logic                          ONCHIP_OSC_I,      // On-chip oscillator clock
  output logic                               TIMER_IRQ_O,       // Underflow interrupt pulse
  output logic      [1:0]                    PIN_ROUTE_O        // Pin routing to port mux
);

  timer_pkg::bus_state_t state;
  timer_pkg::mode_reg_t  mode;
  timer_pkg::pin_reg_t   pin;
  logic [9:0]  idx;
  logic [7:0]  wdata;
  logic        req;
  logic        wr_en;
  logic        wr_ctl;
  logic        wr_pre;
  logic        wr_tmr;
  logic        stop_wr;
  logic [7:0]  rd_mux;
  logic        start;
  logic        status;
  logic        underflow_flag;
  logic [7:0]  io_control;
  logic        osc_meta;
  logic        osc_sync;
  logic        osc_prev;
  logic        osc_tick;
  logic [2:0]  div_cnt;
  logic        src_edge;
  logic        tick;
  logic [7:0]  pre_rld;
  logic [7:0]  pre_cnt;
  logic        pre_pend;
  logic        pre_underflow;
  logic [7:0]  tmr_rld;
  logic [7:0]  tmr_cnt;
  logic        tmr_pend;
  logic        tmr_underflow;

  // Bus decode; low address bits ignored, each register owns a word
  assign idx     = AVS_ADDRESS_I[timer_pkg::ADDR_W-1:2];
  assign wdata   = AVS_WRITEDATA_I[7:0];
  assign req     = AVS_READ_I | AVS_WRITE_I;
  assign wr_en   = CE_I & AVS_WRITE_I & AVS_BYTEENABLE_I[0] &
                   (state == timer_pkg::BUS_ANSWER);
  assign wr_ctl  = wr_en & (idx == timer_pkg::IDX_CONTROL);
  assign wr_pre  = wr_en & (idx == timer_pkg::IDX_PRESCALE);
  assign wr_tmr  = wr_en & (idx == timer_pkg::IDX_TIMER);
  assign stop_wr = wr_ctl & wdata[timer_pkg::STOP_BIT];

  // One wait state: read data is captured first, then released with waitrequest low
  assign AVS_WAITREQUEST_O = req & (state != timer_pkg::BUS_ANSWER);

  // Bus answer state
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= timer_pkg::BUS_IDLE;
    end else if (CE_I) begin
      case (state)
        timer_pkg::BUS_IDLE: begin
          if (req) begin
            state <= timer_pkg::BUS_ANSWER;
          end
        end
        timer_pkg::BUS_ANSWER: begin
          state <= timer_pkg::BUS_IDLE;
        end
        default: begin
          state <= timer_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Read multiplexer; unmapped words read zero
  always_comb begin
    case (idx)
      timer_pkg::IDX_CONTROL: begin
        rd_mux = 8'h00;
        rd_mux[timer_pkg::START_BIT]     = start;
        rd_mux[timer_pkg::STATUS_BIT]    = status;
        rd_mux[timer_pkg::UNDERFLOW_BIT] = underflow_flag; // Stop bit stays 0
      end
      timer_pkg::IDX_IO_CONTROL: rd_mux = io_control;
      timer_pkg::IDX_MODE:       rd_mux = {mode[7:4], 1'b0, mode[2:0]};
      timer_pkg::IDX_PRESCALE:   rd_mux = pre_cnt;
      timer_pkg::IDX_TIMER:      rd_mux = tmr_cnt;
      timer_pkg::IDX_PIN_ASSIGN: rd_mux = pin & timer_pkg::PIN_READ_MASK;
      default:                   rd_mux = 8'h00;
    endcase
  end

  // Read data captured while waitrequest is high, stable at the answer edge
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (CE_I && AVS_READ_I && state == timer_pkg::BUS_IDLE) begin
      AVS_READDATA_O <= {24'h00_0000, rd_mux};
    end
  end

  // Plain configuration registers; software owns ordering of their writes
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      io_control <= timer_pkg::RST_REG;
      mode       <= timer_pkg::RST_REG;
    end else if (CE_I) begin
      if (wr_en && idx == timer_pkg::IDX_IO_CONTROL) begin
        io_control <= wdata;
      end
      if (wr_en && idx == timer_pkg::IDX_MODE) begin
        mode <= wdata;
      end
    end
  end

  // Pin assignment; forbidden code routes nowhere rather than to two pins
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pin         <= timer_pkg::RST_REG;
      PIN_ROUTE_O <= timer_pkg::PIN_NONE;
    end else if (CE_I) begin
      if (wr_en && idx == timer_pkg::IDX_PIN_ASSIGN) begin
        pin <= wdata & timer_pkg::PIN_READ_MASK;
      end
      if (pin.pin_assign_sel == timer_pkg::PIN_FORBIDDEN) begin
        PIN_ROUTE_O <= timer_pkg::PIN_NONE;
      end else begin
        PIN_ROUTE_O <= pin.pin_assign_sel; // Routing only, no drive here
      end
    end
  end

  // Oscillator is asynchronous: two flops, then edge detect on the second
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else if (CE_I) begin
      osc_meta <= ONCHIP_OSC_I;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end
  assign osc_tick = osc_sync & ~osc_prev;

  // Free-running divider for the div2 and div8 sources
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      div_cnt <= 3'h0;
    end else if (CE_I) begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // Count source select; forbidden codes give no edges at all
  always_comb begin
    case (mode.count_source_field)
      timer_pkg::SRC_UNDIV: src_edge = 1'b1;
      timer_pkg::SRC_DIV8:  src_edge = (div_cnt == timer_pkg::DIV8_LAST);
      timer_pkg::SRC_OSC:   src_edge = osc_tick;
      timer_pkg::SRC_DIV2:  src_edge = div_cnt[0];
      default:              src_edge = 1'b0;
    endcase
  end

  // Counting needs timer mode, start set and an uncut source
  assign tick = CE_I & start & src_edge & ~mode.count_source_cutoff &
                (mode.operating_mode_field == timer_pkg::MODE_TIMER);
  assign pre_underflow = tick & (pre_cnt == 8'h00) & ~pre_pend;
  assign tmr_underflow = pre_underflow & (tmr_cnt == 8'h00) & ~tmr_pend;

  // Start, status and underflow flag; an underflow beats a clearing write
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      start          <= 1'b0;
      status         <= 1'b0;
      underflow_flag <= 1'b0;
    end else if (CE_I) begin
      if (stop_wr) begin
        start  <= 1'b0;
        status <= 1'b0;
      end else begin
        if (wr_ctl) begin
          start <= wdata[timer_pkg::START_BIT];
        end
        status <= start;
      end
      if (tmr_underflow) begin
        underflow_flag <= 1'b1;
      end else if (wr_ctl && !wdata[timer_pkg::UNDERFLOW_BIT]) begin
        underflow_flag <= 1'b0;
      end
    end
  end

  // Prescaler: reload and counter; a running write waits for the next source edge
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pre_rld  <= timer_pkg::RST_COUNT;
      pre_cnt  <= timer_pkg::RST_COUNT;
      pre_pend <= 1'b0;
    end else if (CE_I) begin
      if (stop_wr) begin
        pre_rld  <= timer_pkg::RST_COUNT;
        pre_cnt  <= timer_pkg::RST_COUNT;
        pre_pend <= 1'b0;
      end else if (wr_pre) begin
        pre_rld <= wdata;
        if (!start) begin
          pre_cnt <= wdata;
        end
        pre_pend <= start;
      end else if (tick) begin
        if (pre_pend || pre_cnt == 8'h00) begin
          pre_cnt <= pre_rld;
        end else begin
          pre_cnt <= pre_cnt - 8'h01;
        end
        pre_pend <= 1'b0;
      end
    end
  end

  // Timer: steps on prescaler underflow, running write waits for the next one
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tmr_rld  <= timer_pkg::RST_COUNT;
      tmr_cnt  <= timer_pkg::RST_COUNT;
      tmr_pend <= 1'b0;
    end else if (CE_I) begin
      if (stop_wr) begin
        tmr_rld  <= timer_pkg::RST_COUNT;
        tmr_cnt  <= timer_pkg::RST_COUNT;
        tmr_pend <= 1'b0;
      end else if (wr_tmr) begin
        tmr_rld <= wdata;
        if (!start) begin
          tmr_cnt <= wdata;
        end
        tmr_pend <= start;
      end else if (pre_underflow) begin
        if (tmr_pend || tmr_cnt == 8'h00) begin
          tmr_cnt <= tmr_rld;
        end else begin
          tmr_cnt <= tmr_cnt - 8'h01;
        end
        tmr_pend <= 1'b0;
      end
    end
  end

  // Interrupt request, one clock per underflow
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      TIMER_IRQ_O <= 1'b0;
    end else if (CE_I) begin
      TIMER_IRQ_O <= tmr_underflow;
    end
  end

  // Checks on the counting chain and register side effects
  a_start_write: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    wr_ctl && wdata[timer_pkg::START_BIT] && !stop_wr |=> start ##1 (status || !CE_I))
    else $error("start write did not start counting");

  a_stop_holds: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && !start && !wr_pre && !stop_wr |=> pre_cnt == $past(pre_cnt))
    else $error("prescaler moved while stopped");

  a_forced_stop: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    stop_wr |=> !start && !status && pre_cnt == timer_pkg::RST_COUNT &&
    tmr_cnt == timer_pkg::RST_COUNT)
    else $error("forced stop did not reset the timer");

  a_underflow_irq: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    tmr_underflow && !wr_tmr && !stop_wr
    |=> TIMER_IRQ_O && underflow_flag && tmr_cnt == $past(tmr_rld))
    else $error("underflow without interrupt or reload");

  a_pre_reload: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    pre_underflow && !wr_pre && !stop_wr |=> pre_cnt == $past(pre_rld))
    else $error("prescaler did not reload on underflow");

  a_stopped_write: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    wr_pre && !start |=> pre_cnt == $past(wdata) && pre_rld == $past(wdata))
    else $error("stopped write missed the counter");

  a_running_write: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    wr_pre && start && !tick |=> pre_cnt == $past(pre_cnt) && pre_pend)
    else $error("running prescaler write was not deferred");

  a_timer_step: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && !pre_underflow && !wr_tmr && !stop_wr |=> tmr_cnt == $past(tmr_cnt))
    else $error("timer moved without prescaler underflow");

  a_timer_dec: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    pre_underflow && tmr_cnt != 8'h00 && !tmr_pend && !wr_tmr && !stop_wr
    |=> tmr_cnt == 8'($past(tmr_cnt) - 8'h01))
    else $error("timer did not step down by one");

  a_mode_gate: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    CE_I && mode.operating_mode_field != timer_pkg::MODE_TIMER && !wr_pre && !stop_wr
    |=> pre_cnt == $past(pre_cnt))
    else $error("counting outside timer mode");

  a_pin_route: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    PIN_ROUTE_O != timer_pkg::PIN_FORBIDDEN)
    else $error("forbidden pin route driven");

endmodule

// [rtl/timer_pkg.sv]
// Package: register map, field layout, reset values and types of the reload down timer
package timer_pkg;

  // Avalon byte address width; registers sit at four times their index
  localparam int unsigned ADDR_W          = 12;
  localparam logic [9:0]  IDX_CONTROL     = 10'h100;
  localparam logic [9:0]  IDX_IO_CONTROL  = 10'h101;
  localparam logic [9:0]  IDX_MODE        = 10'h102;
  localparam logic [9:0]  IDX_PRESCALE    = 10'h103;
  localparam logic [9:0]  IDX_TIMER       = 10'h104;
  localparam logic [9:0]  IDX_PIN_ASSIGN  = 10'h105;

  // Control register bit positions
  localparam int unsigned START_BIT       = 0;
  localparam int unsigned STATUS_BIT      = 1;
  localparam int unsigned STOP_BIT        = 2;
  localparam int unsigned UNDERFLOW_BIT   = 5;

  // Reset values and the pin read mask
  localparam logic [7:0]  RST_COUNT       = 8'hff;
  localparam logic [7:0]  RST_REG         = 8'h00;
  localparam logic [7:0]  PIN_READ_MASK   = 8'h0f;

  // Operating mode and count source codes
  localparam logic [2:0]  MODE_TIMER      = 3'h0;
  localparam logic [2:0]  SRC_UNDIV       = 3'h0;
  localparam logic [2:0]  SRC_DIV8        = 3'h1;
  localparam logic [2:0]  SRC_OSC         = 3'h2;
  localparam logic [2:0]  SRC_DIV2        = 3'h3;
  localparam logic [2:0]  DIV8_LAST       = 3'h7;

  // Pin assignment codes
  localparam logic [1:0]  PIN_NONE        = 2'h0;
  localparam logic [1:0]  PIN_PORT1_BIT7  = 2'h1;
  localparam logic [1:0]  PIN_PORT1_BIT5  = 2'h2;
  localparam logic [1:0]  PIN_FORBIDDEN   = 2'h3;

  typedef struct packed {
    logic       count_source_cutoff;
    logic [2:0] count_source_field;
    logic       unused;
    logic [2:0] operating_mode_field;
  } mode_reg_t;

  typedef struct packed {
    logic [3:0] unused;
    logic [1:0] reserved;
    logic [1:0] pin_assign_sel;
  } pin_reg_t;

  typedef enum logic {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

endpackage
